// ### core/fpmd_map.svh
// front panel menu display: constants, factory values, glyphs, timing
`ifndef FPMD_MAP_SVH
`define FPMD_MAP_SVH
// -----------------------------------------------------------------
// factory network settings and optical power limit
// -----------------------------------------------------------------
`define FPMD_HA_FACTORY   32'hC0A82705
`define FPMD_NM_FACTORY   32'hFFFFFF00
`define FPMD_OPT_MAX      8'h03
// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define FPMD_CLK_HZ       10000000
`define FPMD_KEY_HOLD_MS  1000
`define FPMD_FLASH_MS     5000
`define FPMD_IDLE_MS      60000
`define FPMD_PHASE_MS     1000
`define FPMD_KEY_HOLD_CYC (`FPMD_KEY_HOLD_MS * (`FPMD_CLK_HZ / 1000))
`define FPMD_FLASH_CYC    (`FPMD_FLASH_MS * (`FPMD_CLK_HZ / 1000))
`define FPMD_IDLE_CYC     (`FPMD_IDLE_MS * (`FPMD_CLK_HZ / 1000))
`define FPMD_PHASE_CYC    (`FPMD_PHASE_MS * (`FPMD_CLK_HZ / 1000))
// -----------------------------------------------------------------
// glyph codes: 00..0F are hex digits
// -----------------------------------------------------------------
`define FPMD_G_DASH       5'h10
`define FPMD_G_BLANK      5'h11
`define FPMD_G_R          5'h12
`define FPMD_G_E          5'h0E
`define FPMD_G_S          5'h05
`define FPMD_G_B          5'h0B
`define FPMD_G_8          5'h08
// key codes {left, right}
`define FPMD_K_LEFT       2'h2
`define FPMD_K_RIGHT      2'h1
`define FPMD_K_BOTH       2'h3
`endif

// ### core/fpmd_pkg.sv
// front panel menu display: shared types
`default_nettype none
package fpmd_pkg;
   typedef enum logic [3:0] {
      DRV_RESET, DRV_INIT, DRV_NOT_READY, DRV_START_INHIBIT,
      DRV_READY, DRV_SWITCHED_ON, DRV_OP_ENABLED, DRV_QUICK_STOP,
      DRV_FAULT_REACT
   } fpmd_drv_t;
   typedef enum logic [2:0] {
      M_STATUS, M_MENU, M_BYTE, M_EDIT, M_FLASH
   } fpmd_mode_t;
   typedef enum logic [2:0] {
      IT_HA_EDIT, IT_HA_RESTORE, IT_NM_EDIT, IT_NM_RESTORE,
      IT_FB_NODE, IT_OPT_PWR
   } fpmd_item_t;
   typedef struct packed {
      logic [4:0] dig_l;
      logic [4:0] dig_r;
      logic       dp_l;
      logic       dp_r;
   } fpmd_disp_t;
   typedef struct packed {
      logic        l_s1;
      logic        l_s2;
      logic        r_s1;
      logic        r_s2;
      logic [1:0]  keys_prev;
      logic [31:0] hold_cnt;
      fpmd_mode_t  mode;
      fpmd_item_t  item;
      logic [1:0]  bsel;
      logic [7:0]  edit;
      logic [31:0] flash_cnt;
      logic [31:0] idle_cnt;
      logic [31:0] sec_cnt;
      logic [1:0]  fphase;
      logic [31:0] ha_st;
      logic [31:0] nm_st;
      logic [31:0] ha_act;
      logic [31:0] nm_act;
      logic [7:0]  fb_node;
      logic [1:0]  opt_pw;
      logic        ack;
      fpmd_disp_t  disp;
   } fpmd_state_t;
endpackage : fpmd_pkg
`default_nettype wire

// ### core/fpmd_top.sv
// front panel menu display: keys, menu, commit and status display
//
// Functional notes
// - factory host address 192.168.39.5 held after reset
// - host address edited per byte, byte 0 is last octet, full range
// - host address restore loads factory address into stored setting
// - netmask edited per byte in hex, same byte order
// - netmask restore loads 255.255.255.0 into stored setting
// - accepted value flashes; key aborts; stored after five seconds
// - stored host address becomes active only after restart
// - node number editable only with field bus, limit from option; else dashes
// - optical power 0 to 3 only with optical option; else dashes
// - status mode shows a distinct code per drive state
// - not-ready/start-inhibit point flashes while safe torque off active
// - switched-on through fault-reaction point flashes while power stage on
// - fault cycles banner, number, location, one second each
// - acknowledge clears fault unless point-marked; those need restart
// - sixty seconds without key input returns to status display
// - menu values shown as two hex digits; fault codes in decimal
`include "fpmd_map.svh"
`default_nettype none
module fpmd_top #(
   parameter int unsigned KEY_HOLD_CYC = `FPMD_KEY_HOLD_CYC,
   parameter int unsigned FLASH_CYC    = `FPMD_FLASH_CYC,
   parameter int unsigned IDLE_CYC     = `FPMD_IDLE_CYC,
   parameter int unsigned PHASE_CYC    = `FPMD_PHASE_CYC
) (
   // clock and reset
   input  wire logic        CLK_IN,
   input  wire logic        RSTN_IN,
   // front panel keys (pins)
   input  wire logic        LEFT_KEY_IN,
   input  wire logic        RIGHT_KEY_IN,
   // drive controller status
   input  wire logic [3:0]  DRV_STATE_IN,
   input  wire logic        SAFE_TORQUE_OFF_ACTIVE_IN,
   input  wire logic        PWR_STAGE_ACTIVE_IN,
   input  wire logic        FAULT_IN,
   input  wire logic        FAULT_POINT_IN,
   input  wire logic [7:0]  FAULT_NUM_IN,
   input  wire logic [7:0]  FAULT_LOC_IN,
   input  wire logic        RESTART_IN,
   // options
   input  wire logic        FB_FITTED_IN,
   input  wire logic        FB_OPTICAL_IN,
   input  wire logic [7:0]  FB_MAX_IN,
   // display
   output logic [4:0]       DIG_L_OUT,
   output logic [4:0]       DIG_R_OUT,
   output logic             DP_L_OUT,
   output logic             DP_R_OUT,
   // settings and acknowledge
   output logic [31:0]      HA_STORED_OUT,
   output logic [31:0]      NM_STORED_OUT,
   output logic [31:0]      HA_ACTIVE_OUT,
   output logic [31:0]      NM_ACTIVE_OUT,
   output logic [7:0]       FB_NODE_OUT,
   output logic [1:0]       OPT_POWER_OUT,
   output logic             FAULT_ACK_OUT
);
   fpmd_pkg::fpmd_state_t q, d;
   logic [1:0] keys;
   logic [1:0] evt;
   logic       avail;
   logic       commit;
   logic       blink;
   logic [7:0] nxt;
   logic [7:0] fval;

   // -----------------------------------------------------------------
   // combinational next state
   // -----------------------------------------------------------------
   always_comb begin
      d = q;
      d.ack = 1'b0;
      evt = 2'h0;
      commit = 1'b0;
      nxt = 8'h00;
      fval = 8'h00;
      // pins pass two flops before use
      d.l_s1 = LEFT_KEY_IN;
      d.l_s2 = q.l_s1;
      d.r_s1 = RIGHT_KEY_IN;
      d.r_s2 = q.r_s1;
      keys = {q.l_s2, q.r_s2};
      d.keys_prev = keys;
      if (keys == 2'h0 || keys != q.keys_prev) begin
         d.hold_cnt = 32'h0;
      end else if (q.hold_cnt == KEY_HOLD_CYC - 1) begin
         evt = keys;
         d.hold_cnt = 32'h0; // held key repeats each second
      end else begin
         d.hold_cnt = q.hold_cnt + 32'h1;
      end
      // free-running second counter drives fault cycling and blink
      if (q.sec_cnt == PHASE_CYC - 1) begin
         d.sec_cnt = 32'h0;
         d.fphase = (q.fphase == 2'h2) ? 2'h0 : q.fphase + 2'h1;
      end else begin
         d.sec_cnt = q.sec_cnt + 32'h1;
      end
      blink = (q.sec_cnt < PHASE_CYC / 2);
      if (!FAULT_IN) begin
         d.fphase = 2'h0;
      end
      avail = !((q.item == fpmd_pkg::IT_FB_NODE && !FB_FITTED_IN) ||
                (q.item == fpmd_pkg::IT_OPT_PWR && !FB_OPTICAL_IN));
      if (evt != 2'h0 || q.mode == fpmd_pkg::M_STATUS) begin
         d.idle_cnt = 32'h0;
      end else begin
         d.idle_cnt = q.idle_cnt + 32'h1;
      end
      // menu state machine
      case (q.mode)
         fpmd_pkg::M_STATUS: begin
            if (evt == `FPMD_K_LEFT) begin
               d.mode = fpmd_pkg::M_MENU;
               d.item = fpmd_pkg::IT_HA_EDIT;
            end
            if (evt == `FPMD_K_BOTH && FAULT_IN && !FAULT_POINT_IN) begin
               d.ack = 1'b1;
            end
         end
         fpmd_pkg::M_MENU: begin
            if (evt == `FPMD_K_LEFT) begin
               d.item = (q.item == fpmd_pkg::IT_OPT_PWR) ?
                        fpmd_pkg::IT_HA_EDIT :
                        fpmd_pkg::fpmd_item_t'(q.item + 3'h1);
            end else if (evt == `FPMD_K_BOTH) begin
               d.mode = fpmd_pkg::M_STATUS;
            end else if (evt == `FPMD_K_RIGHT) begin
               d.bsel = 2'h0;
               d.flash_cnt = 32'h0;
               case (q.item)
                  fpmd_pkg::IT_HA_EDIT,
                  fpmd_pkg::IT_NM_EDIT: d.mode = fpmd_pkg::M_BYTE;
                  fpmd_pkg::IT_HA_RESTORE,
                  fpmd_pkg::IT_NM_RESTORE: d.mode = fpmd_pkg::M_FLASH;
                  fpmd_pkg::IT_FB_NODE: begin
                     d.mode = fpmd_pkg::M_EDIT;
                     d.edit = q.fb_node;
                  end
                  default: begin
                     d.mode = fpmd_pkg::M_EDIT;
                     d.edit = {6'h00, q.opt_pw};
                  end
               endcase
            end
         end
         fpmd_pkg::M_BYTE: begin
            if (evt == `FPMD_K_LEFT) begin
               d.bsel = q.bsel + 2'h1;
            end else if (evt == `FPMD_K_BOTH) begin
               d.mode = fpmd_pkg::M_MENU;
            end else if (evt == `FPMD_K_RIGHT) begin
               d.mode = fpmd_pkg::M_EDIT;
               // byte 0 is the last octet
               d.edit = (q.item == fpmd_pkg::IT_HA_EDIT) ?
                        q.ha_st[{q.bsel, 3'b000} +: 8] :
                        q.nm_st[{q.bsel, 3'b000} +: 8];
            end
         end
         fpmd_pkg::M_EDIT: begin
            // left steps the upper digit, right the lower one
            nxt = (evt == `FPMD_K_LEFT) ? q.edit + 8'h10 : q.edit + 8'h01;
            if (q.item == fpmd_pkg::IT_FB_NODE && nxt > FB_MAX_IN) begin
               nxt = 8'h00;
            end
            if (q.item == fpmd_pkg::IT_OPT_PWR && nxt > `FPMD_OPT_MAX) begin
               nxt = 8'h00;
            end
            if (evt == `FPMD_K_BOTH) begin
               d.mode = avail ? fpmd_pkg::M_FLASH : fpmd_pkg::M_MENU;
               d.flash_cnt = 32'h0;
            end else if (evt != 2'h0 && avail) begin
               d.edit = nxt;
            end
         end
         fpmd_pkg::M_FLASH: begin
            // any key aborts, else commit after five seconds
            if (evt != 2'h0) begin
               d.mode = fpmd_pkg::M_MENU;
            end else if (q.flash_cnt == FLASH_CYC - 1) begin
               d.mode = fpmd_pkg::M_MENU;
               // option pulled mid-flash drops the edit
               commit = avail;
            end else begin
               d.flash_cnt = q.flash_cnt + 32'h1;
            end
         end
         default: d.mode = fpmd_pkg::M_STATUS;
      endcase
      if (q.mode != fpmd_pkg::M_STATUS && q.mode != fpmd_pkg::M_FLASH &&
          q.idle_cnt == IDLE_CYC - 1) begin
         d.mode = fpmd_pkg::M_STATUS;
      end
      // commit touches only the stored copy
      if (commit) begin
         case (q.item)
            fpmd_pkg::IT_HA_EDIT: d.ha_st[{q.bsel, 3'b000} +: 8] = q.edit;
            fpmd_pkg::IT_HA_RESTORE: d.ha_st = `FPMD_HA_FACTORY;
            fpmd_pkg::IT_NM_EDIT: d.nm_st[{q.bsel, 3'b000} +: 8] = q.edit;
            fpmd_pkg::IT_NM_RESTORE: d.nm_st = `FPMD_NM_FACTORY;
            fpmd_pkg::IT_FB_NODE: d.fb_node = q.edit;
            default: d.opt_pw = q.edit[1:0];
         endcase
      end
      // active settings change only at restart
      if (RESTART_IN) begin
         d.ha_act = q.ha_st;
         d.nm_act = q.nm_st;
      end
      // display; points dark unless set below
      d.disp.dp_l = 1'b0;
      d.disp.dp_r = 1'b0;
      d.disp.dig_l = `FPMD_G_DASH;
      d.disp.dig_r = {1'b0, q.item == fpmd_pkg::IT_OPT_PWR ? 4'h6 :
                     {1'b0, q.item} + 4'h1};
      case (q.mode)
         fpmd_pkg::M_STATUS: begin
            if (FAULT_IN) begin
               fval = (q.fphase == 2'h1) ? FAULT_NUM_IN % 8'd100 :
                      FAULT_LOC_IN % 8'd100;
               d.disp.dig_l = (q.fphase == 2'h0) ? `FPMD_G_E :
                              {1'b0, 4'(fval / 8'd10)};
               d.disp.dig_r = (q.fphase == 2'h0) ? `FPMD_G_R :
                              {1'b0, 4'(fval % 8'd10)};
               d.disp.dp_r = (q.fphase == 2'h0) && FAULT_POINT_IN;
            end else begin
               d.disp.dig_l = `FPMD_G_S;
               d.disp.dig_r = {1'b0, DRV_STATE_IN - 4'h1};
               case (fpmd_pkg::fpmd_drv_t'(DRV_STATE_IN))
                  fpmd_pkg::DRV_RESET: begin
                     d.disp.dig_l = `FPMD_G_8;
                     d.disp.dig_r = `FPMD_G_8;
                     d.disp.dp_l = 1'b1;
                     d.disp.dp_r = 1'b1;
                  end
                  fpmd_pkg::DRV_INIT: begin
                     d.disp.dig_l = `FPMD_G_DASH;
                     d.disp.dig_r = `FPMD_G_DASH;
                  end
                  fpmd_pkg::DRV_NOT_READY,
                  fpmd_pkg::DRV_START_INHIBIT:
                     d.disp.dp_r = SAFE_TORQUE_OFF_ACTIVE_IN && blink;
                  fpmd_pkg::DRV_READY: d.disp.dp_r = 1'b0;
                  default: d.disp.dp_r = PWR_STAGE_ACTIVE_IN && blink;
               endcase
            end
         end
         fpmd_pkg::M_BYTE: begin
            d.disp.dig_l = `FPMD_G_B;
            d.disp.dig_r = {3'b000, q.bsel};
         end
         fpmd_pkg::M_EDIT,
         fpmd_pkg::M_FLASH: begin
            d.disp.dig_l = {1'b0, q.edit[7:4]};
            d.disp.dig_r = {1'b0, q.edit[3:0]};
            if (q.item == fpmd_pkg::IT_HA_RESTORE ||
                q.item == fpmd_pkg::IT_NM_RESTORE) begin
               d.disp.dig_l = `FPMD_G_R;
               d.disp.dig_r = `FPMD_G_BLANK;
            end
            if (!avail) begin
               d.disp.dig_l = `FPMD_G_DASH;
               d.disp.dig_r = `FPMD_G_DASH;
            end
            if (q.mode == fpmd_pkg::M_FLASH) begin
               d.disp.dp_l = blink;
               d.disp.dp_r = blink;
            end
         end
         default: ;
      endcase
   end

   // -----------------------------------------------------------------
   // state register
   // -----------------------------------------------------------------
   always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         q <= '0;
         q.ha_st <= `FPMD_HA_FACTORY;
         q.ha_act <= `FPMD_HA_FACTORY;
         q.nm_st <= `FPMD_NM_FACTORY;
         q.nm_act <= `FPMD_NM_FACTORY;
         q.disp.dig_l <= `FPMD_G_8;
         q.disp.dig_r <= `FPMD_G_8;
      end else begin
         q <= d;
      end
   end

   // outputs straight from flops
   assign DIG_L_OUT = q.disp.dig_l;
   assign DIG_R_OUT = q.disp.dig_r;
   assign DP_L_OUT = q.disp.dp_l;
   assign DP_R_OUT = q.disp.dp_r;
   assign HA_STORED_OUT = q.ha_st;
   assign NM_STORED_OUT = q.nm_st;
   assign HA_ACTIVE_OUT = q.ha_act;
   assign NM_ACTIVE_OUT = q.nm_act;
   assign FB_NODE_OUT = q.fb_node;
   assign OPT_POWER_OUT = q.opt_pw;
   assign FAULT_ACK_OUT = q.ack;

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RSTN_IN);

   sequence s_flash_timeout;
      q.mode == fpmd_pkg::M_FLASH && q.flash_cnt == FLASH_CYC - 1 &&
      evt == 2'h0;
   endsequence
   sequence s_flash_abort;
      q.mode == fpmd_pkg::M_FLASH && evt != 2'h0;
   endsequence

   AST_FLASH_ABORT: assert property (
      s_flash_abort |=> q.mode == fpmd_pkg::M_MENU && $stable(q.ha_st) &&
                        $stable(q.nm_st) && $stable(q.fb_node))
      else $error("flash abort changed a stored value");
   AST_HA_RESTORE: assert property (
      s_flash_timeout ##0 q.item == fpmd_pkg::IT_HA_RESTORE
      |=> q.ha_st == `FPMD_HA_FACTORY && q.mode == fpmd_pkg::M_MENU)
      else $error("host address restore did not load factory value");
   AST_NM_RESTORE: assert property (
      s_flash_timeout ##0 q.item == fpmd_pkg::IT_NM_RESTORE
      |=> q.nm_st == `FPMD_NM_FACTORY)
      else $error("netmask restore did not load factory value");
   AST_HA_BYTE: assert property (
      s_flash_timeout ##0 q.item == fpmd_pkg::IT_HA_EDIT
      |=> q.ha_st[{$past(q.bsel), 3'b000} +: 8] == $past(q.edit))
      else $error("host address byte not stored");
   AST_ACTIVE_HOLD: assert property (
      !RESTART_IN |=> $stable(q.ha_act) && $stable(q.nm_act))
      else $error("active address changed without restart");
   AST_RESTART_COPY: assert property (
      RESTART_IN |=> q.ha_act == $past(q.ha_st))
      else $error("restart did not copy stored address");
   AST_IDLE_RETURN: assert property (
      q.mode inside {fpmd_pkg::M_MENU, fpmd_pkg::M_EDIT} &&
      q.idle_cnt == IDLE_CYC - 1 |=> q.mode == fpmd_pkg::M_STATUS)
      else $error("idle timeout did not return to status");
   AST_FB_DASH: assert property (
      q.mode == fpmd_pkg::M_EDIT && q.item == fpmd_pkg::IT_FB_NODE &&
      !FB_FITTED_IN |=> DIG_L_OUT == `FPMD_G_DASH &&
                        DIG_R_OUT == `FPMD_G_DASH)
      else $error("node entry without option not dashed");
   AST_OPT_HOLD: assert property (
      !FB_OPTICAL_IN |=> $stable(q.opt_pw))
      else $error("optical power changed without option");
   AST_STO_DARK: assert property (
      q.mode == fpmd_pkg::M_STATUS && !FAULT_IN &&
      DRV_STATE_IN == 4'(fpmd_pkg::DRV_NOT_READY) &&
      !SAFE_TORQUE_OFF_ACTIVE_IN |=> !DP_R_OUT)
      else $error("point lit with safe torque off inactive");
   AST_FAULT_BANNER: assert property (
      q.mode == fpmd_pkg::M_STATUS && FAULT_IN && q.fphase == 2'h0
      |=> DIG_L_OUT == `FPMD_G_E && DIG_R_OUT == `FPMD_G_R)
      else $error("fault banner not shown in phase 0");
   AST_ACK_POINT: assert property (
      FAULT_POINT_IN |=> !FAULT_ACK_OUT)
      else $error("point-marked fault acknowledged by keys");
endmodule : fpmd_top
`default_nettype wire

// ### bench/fpmd_operator.sv
// operator model: presses the two front panel keys
`default_nettype none
module fpmd_operator #(
   parameter int unsigned HOLD = 4
) (
   // clock
   input  wire logic clk_in,
   // key pins
   output logic      left_key_out,
   output logic      right_key_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // -----------------------------------------------------------------
   // key pressing
   // -----------------------------------------------------------------
   // keys start released
   initial begin
      left_key_out = 1'b0;
      right_key_out = 1'b0;
   end
   // hold past sync plus one hold time, short of a repeat
   // both keys go down in the same cycle
   task automatic press(input logic [1:0] combo);
      @(posedge clk_in);
      {left_key_out, right_key_out} <= combo;
      repeat (HOLD + 3) @(posedge clk_in);
      {left_key_out, right_key_out} <= 2'h0;
      repeat (4) @(posedge clk_in);
   endtask : press
endmodule : fpmd_operator
`default_nettype wire

// ### bench/front_panel_menu_display_tb_top.sv
// testbench for the front panel menu display block
`include "fpmd_map.svh"
`default_nettype none
module front_panel_menu_display_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   // -----------------------------------------------------------------
   // signals
   // -----------------------------------------------------------------
   // short counts keep the run brief
   localparam int unsigned HOLD  = 4;
   localparam int unsigned FLASH = 20;
   localparam int unsigned IDLE  = 200;
   localparam int unsigned PHASE = 8;
   localparam logic [1:0]  KL    = `FPMD_K_LEFT;
   localparam logic [1:0]  KR    = `FPMD_K_RIGHT;
   localparam logic [1:0]  KB    = `FPMD_K_BOTH;
   localparam logic [4:0]  DASH  = `FPMD_G_DASH;
   logic        clk, rstn, lkey, rkey, safe_torque_off_active, pwr, fault, fpoint;
   logic        restart, fb_fit, fb_opt, dp_l, dp_r, ack;
   logic [3:0]  drv_state;
   logic [7:0]  fnum, floc, fb_max, fb_node;
   logic [4:0]  dig_l, dig_r;
   logic [31:0] ha_st, nm_st, ha_act, nm_act;
   logic [1:0]  opt_pw;
   int          err_count, samples_checked, cycles, acks;
   // -----------------------------------------------------------------
   // design and operator
   // -----------------------------------------------------------------
   fpmd_top #(.KEY_HOLD_CYC(HOLD), .FLASH_CYC(FLASH), .IDLE_CYC(IDLE),
      .PHASE_CYC(PHASE)) fpmd_top_i (
      .CLK_IN(clk), .RSTN_IN(rstn), .LEFT_KEY_IN(lkey),
      .RIGHT_KEY_IN(rkey), .DRV_STATE_IN(drv_state),
      .SAFE_TORQUE_OFF_ACTIVE_IN(safe_torque_off_active), .PWR_STAGE_ACTIVE_IN(pwr),
      .FAULT_IN(fault), .FAULT_POINT_IN(fpoint), .FAULT_NUM_IN(fnum),
      .FAULT_LOC_IN(floc), .RESTART_IN(restart), .FB_FITTED_IN(fb_fit),
      .FB_OPTICAL_IN(fb_opt), .FB_MAX_IN(fb_max), .DIG_L_OUT(dig_l),
      .DIG_R_OUT(dig_r), .DP_L_OUT(dp_l), .DP_R_OUT(dp_r),
      .HA_STORED_OUT(ha_st), .NM_STORED_OUT(nm_st),
      .HA_ACTIVE_OUT(ha_act), .NM_ACTIVE_OUT(nm_act),
      .FB_NODE_OUT(fb_node), .OPT_POWER_OUT(opt_pw),
      .FAULT_ACK_OUT(ack));
   fpmd_operator #(.HOLD(HOLD)) fpmd_operator_i (
      .clk_in(clk), .left_key_out(lkey), .right_key_out(rkey));
   // -----------------------------------------------------------------
   // clock, timeout and acknowledge counter
   // -----------------------------------------------------------------
   // 10 MHz clock
   always #50 clk = ~clk;
   // a hang ends the run as a mismatch
   always @(posedge clk) begin
      cycles++;
      if (ack === 1'b1) acks++;
      if (cycles == 4000) begin
         err_count++;
         report_and_stop();
      end
   end
   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // settle 1 ns past the edge so outputs are stable
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic key(input logic [1:0] c);
      fpmd_operator_i.press(c);
      #1;
   endtask : key
   task automatic see(input logic [4:0] l, input logic [4:0] r);
      check({22'h0, dig_l, dig_r}, {22'h0, l, r});
   endtask : see
   // blink is counted over one whole phase, so half must be high
   task automatic status_dp(input logic [3:0] s, input logic st,
                            input logic pw, input int exp);
      int n;
      n = 0;
      drv_state <= s;
      safe_torque_off_active <= st;
      pwr <= pw;
      tick(3);
      repeat (PHASE) begin
         tick(1);
         if (dp_r === 1'b1) n++;
      end
      check(n, exp);
   endtask : status_dp
   task automatic report_and_stop;
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : report_and_stop
   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task automatic test_host_edit;
      int n;
      key(KL);
      see(DASH, 5'h01);
      key(KR);
      see(`FPMD_G_B, 5'h00);
      key(KR);
      see(5'h00, 5'h05);
      key(KR);
      see(5'h00, 5'h06);
      key(KB);
      // both points blink half of each phase while flashing
      n = 0;
      repeat (PHASE) begin
         tick(1);
         if (dp_l === 1'b1) n++;
      end
      check(n, PHASE / 2);
      check(ha_st, 32'hC0A82705);
      tick(FLASH + 6);
      check(ha_st, 32'hC0A82706);
      check(ha_act, 32'hC0A82705);
      restart <= 1'b1;
      tick(1);
      restart <= 1'b0;
      tick(2);
      check(ha_act, 32'hC0A82706);
   endtask : test_host_edit
   // a key during the flash must throw the edit away
   task automatic test_abort;
      key(KR);
      key(KR);
      see(5'h00, 5'h06);
      key(KR);
      key(KB);
      key(KL);
      tick(FLASH + 6);
      check(ha_st, 32'hC0A82706);
   endtask : test_abort
   task automatic test_restore_netmask;
      key(KL);
      see(DASH, 5'h02);
      key(KR);
      tick(FLASH + 6);
      check(ha_st, 32'hC0A82705);
      key(KL);
      key(KR);
      key(KR);
      see(5'h00, 5'h00);
      key(KR);
      key(KB);
      tick(FLASH + 6);
      check(nm_st, 32'hFFFFFF01);
      check(nm_act, 32'hFFFFFF00);
      restart <= 1'b1;
      tick(1);
      restart <= 1'b0;
      tick(2);
      check(nm_act, 32'hFFFFFF01);
      check(ha_act, 32'hC0A82705);
      key(KL);
      key(KR);
      tick(FLASH + 6);
      check(nm_st, 32'hFFFFFF00);
   endtask : test_restore_netmask
   task automatic test_options;
      key(KL);
      key(KR);
      see(DASH, DASH);
      key(KB);
      // with the option fitted, 11 is past the limit 0A and wraps
      fb_fit <= 1'b1;
      key(KR);
      key(KR);
      key(KL);
      see(5'h00, 5'h00);
      key(KR);
      key(KB);
      tick(FLASH + 6);
      check(fb_node, 32'h01);
      key(KL);
      key(KR);
      see(5'h00, 5'h00);
      key(KR);
      key(KB);
      tick(FLASH + 6);
      check(opt_pw, 32'h1);
      // optical option gone: dashes, value untouched
      fb_opt <= 1'b0;
      key(KR);
      see(DASH, DASH);
      key(KB);
      check(opt_pw, 32'h1);
      key(KB);
   endtask : test_options
   task automatic test_status;
      for (int s = 2; s <= 8; s++) begin
         drv_state <= 4'(s);
         tick(3);
         see(5'h05, 5'(s - 1));
      end
      status_dp(4'h2, 1'b1, 1'b0, PHASE / 2);
      status_dp(4'h3, 1'b0, 1'b0, 0);
      status_dp(4'h5, 1'b0, 1'b1, PHASE / 2);
      status_dp(4'h4, 1'b0, 1'b1, 0);
      status_dp(4'h8, 1'b0, 1'b0, 0);
   endtask : test_status
   // number 123 shows as decimal 23, location as 05
   task automatic test_fault;
      logic [2:0] seen;
      seen = 3'h0;
      fault <= 1'b1;
      repeat (3 * PHASE + 8) begin
         tick(1);
         if ({dig_l, dig_r} === {`FPMD_G_E, `FPMD_G_R}) seen[0] = 1'b1;
         if ({dig_l, dig_r} === {5'h02, 5'h03}) seen[1] = 1'b1;
         if ({dig_l, dig_r} === {5'h00, 5'h05}) seen[2] = 1'b1;
      end
      check(seen, 32'h7);
      key(KB);
      check(acks, 1);
      fpoint <= 1'b1;
      key(KB);
      check(acks, 1);
   endtask : test_fault
   task automatic test_idle;
      fault <= 1'b0;
      drv_state <= 4'h6;
      key(KL);
      see(DASH, 5'h01);
      tick(IDLE + 10);
      see(5'h05, 5'h05);
   endtask : test_idle
   // -----------------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------------
   initial begin
      {clk, rstn, safe_torque_off_active, pwr, fault, fpoint, restart, fb_fit} = 8'h00;
      err_count = 0;
      samples_checked = 0;
      cycles = 0;
      acks = 0;
      fb_opt = 1'b1;
      drv_state = 4'h0;
      fnum = 8'd123;
      floc = 8'd5;
      fb_max = 8'h0A;
      tick(2);
      see(`FPMD_G_8, `FPMD_G_8);
      check(ha_st, 32'hC0A82705);
      check(ha_act, 32'hC0A82705);
      check(nm_st, 32'hFFFFFF00);
      rstn <= 1'b1;
      tick(1);
      check(dp_l, 32'h1);
      test_host_edit();
      test_abort();
      test_restore_netmask();
      test_options();
      test_status();
      test_fault();
      test_idle();
      report_and_stop();
   end
endmodule : front_panel_menu_display_tb_top
`default_nettype wire
